// ### design/emw_top.sv
// Implementation choice: the strobed register port.
module emw_top (
   input  wire logic                     i_mclk,
   input  wire logic                     i_nrst,
   input  wire logic [emw_pkg::AW-1:0]   i_addr,
   input  wire logic [emw_pkg::DW-1:0]   i_wdata,
   input  wire logic [3:0]               i_be,
   input  wire logic                     i_wr,
   input  wire logic                     i_rd,
   output logic      [emw_pkg::DW-1:0]   o_rdata,
   input  wire emw_pkg::emw_rmii_t       i_rmii,
   input  wire logic                     i_tx_done,
   input  wire logic                     i_tx_own,
   input  wire logic                     i_rx_own,
   output logic                          o_wake_irq,
   output logic                          o_pdown,
   output emw_pkg::emw_glue_t            o_glue,
   output logic                          o_pause_req,
   output logic                          o_backpress,
   output logic                          o_mac_tx_on,
   output logic                          o_mac_rx_on,
   output logic                          o_tx_dma_run,
   output logic                          o_rx_dma_run
);
   import emw_pkg::*;

   // ==========================================
   // Receive path, sampled from the link pins
   emw_rmii_t  rx_s1, rx_s2, rx_s3;
   logic       hunt, next_hunt;
   logic [1:0] dcnt, next_dcnt;
   logic [7:0] sh, next_sh;
   logic [7:0] bcnt, next_bcnt;
   logic       byte_vld, next_byte_vld;
   logic       sof, next_sof;
   logic       mcast, next_mcast;
   logic       wake_evt, next_wake_evt;
   logic [NFILT-1:0] hit;
   logic [DW-1:0] slot [0:NSLOT-1];
   logic [DW-1:0] next_slot [0:NSLOT-1];

   // Receive logic is not gated by power-down, only by the MAC receiver enable, so wake detection survives power-down
   always_comb begin // R8
      next_hunt     = hunt;
      next_dcnt     = dcnt;
      next_sh       = sh;
      next_bcnt     = bcnt;
      next_byte_vld = 1'b0;
      next_sof      = 1'b0;
      next_mcast    = mcast;
      next_wake_evt = 1'b0;
      if (rx_s2.clk && !rx_s3.clk) begin
         if (!rx_s2.dv) begin
            next_hunt     = 1'b1;
            next_wake_evt = !hunt && (|hit); // R7
         end else if (!o_mac_rx_on) begin
            next_hunt = 1'b1;
         end else if (hunt) begin
            if (rx_s2.d == DIBIT_SFD) begin
               next_hunt = 1'b0;
               next_dcnt = 2'h0;
               next_bcnt = 8'h00;
               next_sof  = 1'b1;
            end
         end else begin
            next_sh   = {rx_s2.d, sh[7:2]};
            next_dcnt = dcnt + 2'h1;
            next_byte_vld = (dcnt == 2'h3);
         end
      end
      if (byte_vld && bcnt != BCNT_MAX) begin
         next_bcnt = bcnt + 8'h01;
      end
      if (byte_vld && bcnt == 8'h00) begin
         next_mcast = sh[0];
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         rx_s1    <= '0;
         rx_s2    <= '0;
         rx_s3    <= '0;
         hunt     <= 1'b1;
         dcnt     <= 2'h0;
         sh       <= 8'h00;
         bcnt     <= 8'h00;
         byte_vld <= 1'b0;
         sof      <= 1'b0;
         mcast    <= 1'b0;
         wake_evt <= 1'b0;
      end else begin
         rx_s1    <= i_rmii;
         rx_s2    <= rx_s1;
         rx_s3    <= rx_s2;
         hunt     <= next_hunt;
         dcnt     <= next_dcnt;
         sh       <= next_sh;
         bcnt     <= next_bcnt;
         byte_vld <= next_byte_vld;
         sof      <= next_sof;
         mcast    <= next_mcast;
         wake_evt <= next_wake_evt;
      end
   end

   // ==========================================
   // Wake-up filters
   for (genvar f = 0; f < NFILT; f++) begin : g_filt
      logic [15:0] crc, next_crc;
      logic [30:0] mask;
      logic [3:0]  cmd;
      logic [7:0]  ofs;
      logic [7:0]  rel;
      logic [15:0] ref_crc;
      assign mask    = slot[f][30:0];
      assign cmd     = slot[SLOT_CMD][f*8 +: 4];
      assign ofs     = slot[SLOT_OFS][f*8 +: 8];
      assign ref_crc = slot[SLOT_CRC + f/2][(f%2)*16 +: 16];
      assign rel     = bcnt - ofs;
      // Bit 31 of the mask is never looked at
      always_comb begin // R3 R5 R6
         next_crc = crc;
         if (sof) begin
            next_crc = CRC_INIT;
         end else if (byte_vld && bcnt >= ofs && rel < MASK_LEN && mask[rel[4:0]]) begin
            next_crc = emw_crc8(crc, sh);
         end
      end
      always_ff @(posedge i_mclk or negedge i_nrst) begin
         if (!i_nrst) begin
            crc <= CRC_INIT;
         end else begin
            crc <= next_crc;
         end
      end
      // Reserved command bits 2:1 do not matter
      assign hit[f] = cmd[CMD_EN] && (cmd[CMD_MCAST] == mcast) && (crc == ref_crc); // R4 R7
   end

   // ==========================================
   // Register port
   logic [2:0]        ptr, next_ptr;
   logic              be_mode, next_be_mode;
   logic              fdx, next_fdx;
   logic              wfe, next_wfe;
   logic              txdone, next_txdone;
   logic              nis, next_nis;
   logic [GLUE_W-1:0] glue_a, next_glue_a;
   logic [GLUE_W-1:0] glue_b, next_glue_b;
   emw_dma_t          tx_state, next_tx_state;
   emw_dma_t          rx_state, next_rx_state;
   logic [DW-1:0]     next_rdata;
   logic              next_irq, next_pdown;
   logic              next_mac_tx, next_mac_rx, next_tx_run, next_rx_run;
   logic              lane, win_acc;
   emw_glue_t         next_glue;

   assign lane    = be_mode ? i_be[LANE_BE] : i_be[LANE_MSB];
   assign win_acc = (i_wr || i_rd) && (i_addr == OFS_WAKE);

   always_comb begin
      next_slot    = slot;
      next_ptr     = ptr;
      next_be_mode = be_mode;
      next_fdx     = fdx;
      next_wfe     = wfe;
      next_glue_a  = glue_a;
      next_glue_b  = glue_b;
      next_mac_tx  = o_mac_tx_on;
      next_mac_rx  = o_mac_rx_on;
      next_tx_run  = o_tx_dma_run;
      next_rx_run  = o_rx_dma_run;
      next_pdown   = o_pdown;
      next_irq     = o_wake_irq;
      next_txdone  = txdone;
      next_nis     = nis;
      next_rdata   = '0;
      next_tx_state = tx_state;
      next_rx_state = rx_state;
      if (i_wr) begin
         unique case (i_addr)
            OFS_WAKE: begin
               for (int b = 0; b < 4; b++) begin
                  if (i_be[b]) begin
                     next_slot[ptr][b*8 +: 8] = i_wdata[b*8 +: 8]; // R1
                  end
               end
            end
            OFS_MACCFG: begin
               next_mac_tx = i_wdata[MC_TX_ON]; // R24
               next_mac_rx = i_wdata[MC_RX_ON]; // R24
               next_fdx    = i_wdata[MC_FDX];
            end
            OFS_PMT: begin
               next_pdown = i_wdata[PM_PDOWN];
               next_wfe   = i_wdata[PM_WFE];
            end
            OFS_BUSCFG: next_be_mode = i_wdata[0];
            OFS_OPMODE: begin
               next_rx_run = i_wdata[OM_RX_RUN]; // R22
               next_tx_run = i_wdata[OM_TX_RUN]; // R22
            end
            OFS_STATUS: begin
               if (i_wdata[ST_TXDONE]) next_txdone = 1'b0; // R21
               if (i_wdata[ST_NIS]) next_nis = 1'b0; // R21
            end
            OFS_GLUE_A: next_glue_a = i_wdata[GLUE_W-1:0];
            OFS_GLUE_B: next_glue_b = i_wdata[GLUE_W-1:0];
            default: ;
         endcase
      end
      if (i_rd) begin
         unique case (i_addr)
            OFS_WAKE:   next_rdata = slot[ptr]; // R1
            OFS_MACCFG: begin
               next_rdata[MC_TX_ON] = o_mac_tx_on;
               next_rdata[MC_RX_ON] = o_mac_rx_on;
               next_rdata[MC_FDX]   = fdx;
            end
            OFS_PMT: begin
               next_rdata[PM_PDOWN] = o_pdown;
               next_rdata[PM_WFE]   = wfe;
               next_rdata[PM_WAKE]  = o_wake_irq;
               next_irq = 1'b0; // R10
            end
            OFS_BUSCFG: next_rdata[0] = be_mode;
            OFS_OPMODE: begin
               next_rdata[OM_RX_RUN] = o_rx_dma_run;
               next_rdata[OM_TX_RUN] = o_tx_dma_run;
            end
            OFS_STATUS: begin
               next_rdata[ST_TXDONE] = txdone;
               next_rdata[ST_NIS]    = nis;
               next_rdata[ST_TXSUSP] = (tx_state == DMA_SUSP);
               next_rdata[ST_RXSUSP] = (rx_state == DMA_SUSP);
            end
            OFS_GLUE_A: next_rdata[GLUE_W-1:0] = glue_a;
            OFS_GLUE_B: next_rdata[GLUE_W-1:0] = glue_b;
            default: ;
         endcase
      end
      // Pointer wraps from 7 to 0 by its width
      if (win_acc && lane) begin
         next_ptr = ptr + 3'h1; // R2 R25
      end
      // Sets come last so an event beats a clear in the same cycle
      if (i_tx_done) begin
         next_txdone = 1'b1;
         next_nis    = 1'b1;
      end
      if (wake_evt && o_pdown && wfe) begin
         next_irq   = 1'b1; // R9
         next_pdown = 1'b0; // R9
      end
      unique case (tx_state)
         DMA_STOP: if (o_tx_dma_run) next_tx_state = DMA_RUN;
         DMA_RUN:  if (!i_tx_own) next_tx_state = DMA_SUSP; // R23
         DMA_SUSP: if (i_wr && i_addr == OFS_TXPOLL) next_tx_state = DMA_RUN; // R23
      endcase
      unique case (rx_state)
         DMA_STOP: if (o_rx_dma_run) next_rx_state = DMA_RUN;
         DMA_RUN:  if (!i_rx_own) next_rx_state = DMA_SUSP; // R23
         DMA_SUSP: if (i_wr && i_addr == OFS_RXPOLL) next_rx_state = DMA_RUN; // R23
      endcase
      if (!o_tx_dma_run) next_tx_state = DMA_STOP; // R22
      if (!o_rx_dma_run) next_rx_state = DMA_STOP;
   end

   // Glue fields, decoded one cycle behind their registers
   always_comb begin
      next_glue.if_rgmii   = (glue_a[8:6] == PHY_RGMII); // R12
      next_glue.if_rmii    = (glue_a[8:6] == PHY_RMII); // R12
      next_glue.speed100   = glue_a[10]; // R14
      next_glue.rmii_clk25 = glue_a[11]; // R15
      next_glue.rgmii_clk  = glue_a[13:12]; // R16
      next_glue.rmii_mode  = glue_a[14]; // R17
      next_glue.tx_dly     = glue_b[6:0]; // R18
      next_glue.rx_dly     = glue_b[13:7]; // R18
      next_glue.tx_dly_en  = glue_b[14]; // R19
      next_glue.rx_dly_en  = glue_b[15]; // R19
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int s = 0; s < NSLOT; s++) begin
            slot[s] <= '0;
         end
         ptr          <= 3'h0;
         be_mode      <= 1'b0;
         fdx          <= 1'b0;
         wfe          <= 1'b0;
         glue_a       <= '0;
         glue_b       <= '0;
         txdone       <= 1'b0;
         nis          <= 1'b0;
         tx_state     <= DMA_STOP;
         rx_state     <= DMA_STOP;
         o_rdata      <= '0;
         o_wake_irq   <= 1'b0;
         o_pdown      <= 1'b0;
         o_glue       <= '0;
         o_pause_req  <= 1'b0;
         o_backpress  <= 1'b0;
         o_mac_tx_on  <= 1'b0;
         o_mac_rx_on  <= 1'b0;
         o_tx_dma_run <= 1'b0;
         o_rx_dma_run <= 1'b0;
      end else begin
         slot         <= next_slot;
         ptr          <= next_ptr;
         be_mode      <= next_be_mode;
         fdx          <= next_fdx;
         wfe          <= next_wfe;
         glue_a       <= next_glue_a;
         glue_b       <= next_glue_b;
         txdone       <= next_txdone;
         nis          <= next_nis;
         tx_state     <= next_tx_state;
         rx_state     <= next_rx_state;
         o_rdata      <= next_rdata;
         o_wake_irq   <= next_irq;
         o_pdown      <= next_pdown;
         o_glue       <= next_glue;
         o_pause_req  <= glue_a[9] && fdx; // R13
         o_backpress  <= glue_a[9] && !fdx; // R13
         o_mac_tx_on  <= next_mac_tx;
         o_mac_rx_on  <= next_mac_rx;
         o_tx_dma_run <= next_tx_run;
         o_rx_dma_run <= next_rx_run;
      end
   end

   // ==========================================
   // Assertions
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);

   property p_ptr_adv;
      win_acc && lane && ptr != 3'h7 |=> ptr == $past(ptr) + 3'h1;
   endproperty
   a_ptr_adv: assert property (p_ptr_adv) else $error("slot pointer did not step"); // R2
   property p_ptr_hold;
      win_acc && !lane |=> $stable(ptr);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("slot pointer moved"); // R2
   property p_ptr_wrap;
      win_acc && lane && ptr == 3'h7 |=> ptr == 3'h0;
   endproperty
   a_ptr_wrap: assert property (p_ptr_wrap) else $error("slot pointer did not wrap"); // R25
   property p_win_rd;
      i_rd && i_addr == OFS_WAKE |=> o_rdata == $past(slot[ptr]) ##1 o_rdata == '0 || $past(i_rd);
   endproperty
   a_win_rd: assert property (p_win_rd) else $error("window read data wrong"); // R1
   property p_wake;
      wake_evt && o_pdown && wfe |=> o_wake_irq && !o_pdown;
   endproperty
   a_wake: assert property (p_wake) else $error("wake not raised"); // R9
   property p_wake_clr;
      o_wake_irq && i_rd && i_addr == OFS_PMT && !wake_evt |=> !o_wake_irq;
   endproperty
   a_wake_clr: assert property (p_wake_clr) else $error("wake not cleared on read"); // R10
   property p_w1c;
      i_wr && i_addr == OFS_STATUS && i_wdata[ST_TXDONE] && !i_tx_done |=> !txdone;
   endproperty
   a_w1c: assert property (p_w1c) else $error("status bit not cleared"); // R21
   property p_dma_run;
      i_wr && i_addr == OFS_OPMODE |=> o_tx_dma_run == $past(i_wdata[OM_TX_RUN])
         && o_rx_dma_run == $past(i_wdata[OM_RX_RUN]);
   endproperty
   a_dma_run: assert property (p_dma_run) else $error("dma run bits wrong"); // R22
   property p_susp;
      tx_state == DMA_RUN && !i_tx_own && o_tx_dma_run |=> tx_state == DMA_SUSP;
   endproperty
   a_susp: assert property (p_susp) else $error("tx dma did not suspend"); // R23
   property p_mac_on;
      i_wr && i_addr == OFS_MACCFG |=> o_mac_tx_on == $past(i_wdata[MC_TX_ON]);
   endproperty
   a_mac_on: assert property (p_mac_on) else $error("mac transmitter enable wrong"); // R24
   property p_pause;
      glue_a[9] && fdx |=> o_pause_req && !o_backpress;
   endproperty
   a_pause: assert property (p_pause) else $error("pause request missing"); // R13

   c_wake: cover property (wake_evt && o_pdown && wfe);
   c_wrap: cover property (win_acc && lane && ptr == 3'h7);
   c_resume: cover property (tx_state == DMA_SUSP ##1 tx_state == DMA_RUN);
endmodule : emw_top

// ### design/emw_pkg.sv
// What this block does
// R1 - One window address reaches eight filter words in order; reads walk the same order.
// R2 - Slot pointer advances only when the top byte lane (lane 0 big-endian) is used.
// R3 - Byte mask bit j puts frame byte offset+j into that filter's CRC; bit 31 zero.
// R4 - Four-bit command: bit 0 enables, bit 3 multicast else unicast, bits 2:1 reserved.
// R5 - Eight-bit offset marks first examined byte; software keeps it at 12 or more.
// R6 - Each filter holds a 16-bit expected CRC compared with the masked-byte CRC.
// R7 - Wake frame: enabled filter, matching address type, and equal CRC.
// R8 - No clock is gated here; receive path keeps working in power-down.
// R9 - A valid wake frame raises the wake interrupt and leaves power-down.
// R10 - Reading the power-management register clears the pending wake interrupt.
// R11 - Software powers down: stop TX DMA, disable MAC, drain, arm, enable RX, gate clocks.
// R12 - Interface select field: 001 is RGMII, 100 is RMII, others reserved.
// R13 - Flow control high sends PAUSE in full duplex, back-pressure in half duplex.
// R14 - Speed bit: 1 selects 100 Mbps, 0 selects 10 Mbps.
// R15 - RMII clock bit: 1 selects 25 MHz, 0 selects 2.5 MHz.
// R16 - RGMII clock field: 00 is 125 MHz, 11 is 25 MHz, 10 is 2.5 MHz.
// R17 - RMII mode bit 1 selects RMII; 0 is reserved.
// R18 - RGMII delaylines of 100 elements; TX value bits 6:0, RX value bits 13:7.
// R19 - TX delayline active with bit 14, RX with bit 15, else bypassed.
// R20 - Software builds DMA-owned descriptor chains, two or more with second-frame mode.
// R21 - DMA status interrupt bits clear on write of one, e.g. bit 16 summary.
// R22 - Op mode bit 1 runs receive DMA, bit 13 runs transmit DMA.
// R23 - Descriptor not owned suspends that direction; poll-demand write resumes it.
// R24 - MAC configuration bit 3 enables transmitter, bit 2 enables receiver.
// R25 - After slot 7 the pointer returns to slot 0.
package emw_pkg;
   localparam int AW = 16;
   localparam int DW = 32;
   localparam int NFILT = 4;
   localparam int NSLOT = 8;
   // ==========================================
   // Register offsets
   localparam logic [AW-1:0] OFS_MACCFG  = 16'h0000;
   localparam logic [AW-1:0] OFS_WAKE    = 16'h0028;
   localparam logic [AW-1:0] OFS_PMT     = 16'h002C;
   localparam logic [AW-1:0] OFS_BUSCFG  = 16'h0030;
   localparam logic [AW-1:0] OFS_TXPOLL  = 16'h1004;
   localparam logic [AW-1:0] OFS_RXPOLL  = 16'h1008;
   localparam logic [AW-1:0] OFS_STATUS  = 16'h1014;
   localparam logic [AW-1:0] OFS_OPMODE  = 16'h1018;
   localparam logic [AW-1:0] OFS_GLUE_A  = 16'h2004;
   localparam logic [AW-1:0] OFS_GLUE_B  = 16'h200C;
   // ==========================================
   // Field positions
   localparam int MC_RX_ON   = 2;
   localparam int MC_TX_ON   = 3;
   localparam int MC_FDX     = 11;
   localparam int PM_PDOWN   = 0;
   localparam int PM_WFE     = 2;
   localparam int PM_WAKE    = 6;
   localparam int OM_RX_RUN  = 1;
   localparam int OM_TX_RUN  = 13;
   localparam int ST_TXDONE  = 0;
   localparam int ST_RXSUSP  = 17;
   localparam int ST_TXSUSP  = 20;
   localparam int ST_NIS     = 16;
   localparam int LANE_MSB   = 3;
   localparam int LANE_BE    = 0;
   localparam int CMD_EN     = 0;
   localparam int CMD_MCAST  = 3;
   localparam int GLUE_W     = 16;
   // ==========================================
   // Filter word layout and CRC
   localparam int SLOT_CMD   = 4;
   localparam int SLOT_OFS   = 5;
   localparam int SLOT_CRC   = 6;
   localparam logic [7:0]  MASK_LEN = 8'h1F;
   localparam logic [7:0]  BCNT_MAX = 8'hFF;
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [1:0]  DIBIT_SFD = 2'h3;
   localparam logic [2:0]  PHY_RGMII = 3'h1;
   localparam logic [2:0]  PHY_RMII  = 3'h4;

   typedef struct packed {
      logic       clk;
      logic       dv;
      logic [1:0] d;
   } emw_rmii_t;

   typedef struct packed {
      logic       if_rgmii;
      logic       if_rmii;
      logic       speed100;
      logic       rmii_clk25;
      logic [1:0] rgmii_clk;
      logic       rmii_mode;
      logic       tx_dly_en;
      logic [6:0] tx_dly;
      logic       rx_dly_en;
      logic [6:0] rx_dly;
   } emw_glue_t;

   typedef enum logic [1:0] {DMA_STOP, DMA_RUN, DMA_SUSP} emw_dma_t;

   function automatic logic [15:0] emw_crc8(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int k = 0; k < 8; k++) begin
         r = (r[15] ^ d[k]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      return r;
   endfunction : emw_crc8
endpackage : emw_pkg

// ### verif/emw_phy_model.sv
module emw_phy_model (
   output emw_pkg::emw_rmii_t o_rmii
);
   timeunit 1ns;
   timeprecision 1ps;
   import emw_pkg::*;
   // ==========================================
   // Receive line driver, 80 ns line clock
   // Clock stands still between frames; data toggles so no stale value looks valid
   initial o_rmii = '0;

   task automatic put(input logic [1:0] v);
      o_rmii.d = v;
      #40 o_rmii.clk = 1'b1;
      #40 o_rmii.clk = 1'b0;
   endtask : put

   task automatic send(input logic [7:0] f[$]);
      o_rmii.dv = 1'b1;
      for (int k = 0; k < 8; k++) begin
         put((k == 7) ? DIBIT_SFD : 2'h1);
      end
      foreach (f[i]) begin
         for (int k = 0; k < 4; k++) begin
            put(f[i][2*k +: 2]);
         end
      end
      o_rmii.dv = 1'b0;
      put(~o_rmii.d);
      put(~o_rmii.d);
      o_rmii.d = ~o_rmii.d;
   endtask : send
endmodule : emw_phy_model

// ### verif/tb_ethernet_mac_wake_filter_and_glue.sv
module tb_ethernet_mac_wake_filter_and_glue;
   timeunit 1ns;
   timeprecision 1ps;
   import emw_pkg::*;
   logic          i_mclk;
   logic          i_nrst;
   logic [AW-1:0] i_addr;
   logic [DW-1:0] i_wdata;
   logic [3:0]    i_be;
   logic          i_wr, i_rd, i_tx_done, i_tx_own, i_rx_own;
   logic [DW-1:0] o_rdata;
   emw_rmii_t     i_rmii;
   emw_glue_t     o_glue;
   logic          o_wake_irq, o_pdown, o_pause_req, o_backpress;
   logic          o_mac_tx_on, o_mac_rx_on, o_tx_dma_run, o_rx_dma_run;
   int            checks, bad_count;
   integer        seed;
   logic [31:0]   slot [8];
   logic [31:0]   a, b, c, m, r;
   logic [7:0]    fr [$];
   logic [7:0]    fb [$];

   emw_top u_dut (
      .i_mclk       (i_mclk),
      .i_nrst       (i_nrst),
      .i_addr       (i_addr),
      .i_wdata      (i_wdata),
      .i_be         (i_be),
      .i_wr         (i_wr),
      .i_rd         (i_rd),
      .o_rdata      (o_rdata),
      .i_rmii       (i_rmii),
      .i_tx_done    (i_tx_done),
      .i_tx_own     (i_tx_own),
      .i_rx_own     (i_rx_own),
      .o_wake_irq   (o_wake_irq),
      .o_pdown      (o_pdown),
      .o_glue       (o_glue),
      .o_pause_req  (o_pause_req),
      .o_backpress  (o_backpress),
      .o_mac_tx_on  (o_mac_tx_on),
      .o_mac_rx_on  (o_mac_rx_on),
      .o_tx_dma_run (o_tx_dma_run),
      .o_rx_dma_run (o_rx_dma_run)
   );
   emw_phy_model u_phy (.o_rmii(i_rmii));

   always #4 i_mclk = ~i_mclk;

   // ==========================================
   // Bus access and checking
   // Each access lets an edge pass after the strobe drops, so no signal is set twice at once
   task automatic bus_wr(input logic [15:0] ad, input logic [31:0] d, input logic [3:0] be);
      i_addr <= ad;
      i_wdata <= d;
      i_be <= be;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      @(posedge i_mclk);
   endtask : bus_wr

   task automatic bus_rd(input logic [15:0] ad, input logic [3:0] be, output logic [31:0] d);
      i_addr <= ad;
      i_be <= be;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      // Read data stand only in this cycle; take them once they have settled
      #1 d = o_rdata;
      @(posedge i_mclk);
   endtask : bus_rd

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up

   function automatic emw_glue_t glue_exp(input logic [31:0] ga, input logic [31:0] gb);
      return '{if_rgmii: ga[8:6] == 3'h1, if_rmii: ga[8:6] == 3'h4, speed100: ga[10],
               rmii_clk25: ga[11], rgmii_clk: ga[13:12], rmii_mode: ga[14],
               tx_dly_en: gb[14], tx_dly: gb[6:0], rx_dly_en: gb[15], rx_dly: gb[13:7]};
   endfunction : glue_exp

   // Pattern always starts at byte 12, the lowest offset software may use
   function automatic logic [15:0] crc_of(input logic [7:0] f[$], input logic [31:0] msk);
      logic [15:0] cr;
      cr = 16'hFFFF;
      for (int j = 0; j < 31; j++) begin
         for (int k = 0; k < 8; k++) begin
            if (msk[j]) begin
               cr = (cr[15] ^ f[12 + j][k]) ? ({cr[14:0], 1'b0} ^ 16'h8005) : {cr[14:0], 1'b0};
            end
         end
      end
      return cr;
   endfunction : crc_of

   // The whole run needs well under 40 us; this limit stays below 100k clocks
   initial begin
      #400000;
      bad_count++;
      wrap_up();
   end

   // ==========================================
   // Scenarios
   initial begin
      {i_mclk, i_addr, i_wdata, i_be, i_wr, i_rd, i_tx_done, i_nrst} = '0;
      i_tx_own = 1'b1;
      i_rx_own = 1'b1;
      seed = 32'h53B0;
      repeat (12) @(posedge i_mclk);
      i_nrst <= 1'b1;
      @(posedge i_mclk);
      chk(32'(o_glue), 32'h0);
      chk(32'({o_wake_irq, o_pdown, o_pause_req, o_backpress, o_mac_tx_on, o_mac_rx_on,
               o_tx_dma_run, o_rx_dma_run}), 32'h0);
      for (int i = 0; i < 8; i++) begin
         slot[i] = $random(seed);
         if (i < 4) slot[i][31] = 1'b0;
         if (i == 5) slot[i] = slot[i] | 32'h0C0C0C0C;
         bus_wr(OFS_WAKE, slot[i], 4'hF);
      end
      bus_rd(OFS_WAKE, 4'h7, r);
      chk(r, slot[0]);
      for (int i = 0; i < 8; i++) begin
         bus_rd(OFS_WAKE, 4'hF, r);
         chk(r, slot[i]);
      end
      bus_wr(OFS_BUSCFG, 32'h1, 4'hF);
      bus_rd(OFS_WAKE, 4'h8, r);
      chk(r, slot[0]);
      for (int i = 0; i < 8; i++) begin
         bus_rd(OFS_WAKE, 4'h1, r);
         chk(r, slot[i]);
      end
      bus_wr(OFS_BUSCFG, 32'h0, 4'hF);
      $display("window test done");
      for (int i = 0; i < 8; i++) begin
         a = $random(seed);
         a[8:6] = i[2:0];
         b = $random(seed);
         c = $random(seed);
         m = $random(seed);
         bus_wr(OFS_GLUE_A, a, 4'hF);
         bus_wr(OFS_GLUE_B, b, 4'hF);
         bus_wr(OFS_MACCFG, c, 4'hF);
         bus_wr(OFS_OPMODE, m, 4'hF);
         repeat (3) @(posedge i_mclk);
         chk(32'(o_glue), 32'(glue_exp(a, b)));
         chk({28'h0, o_pause_req, o_backpress, o_mac_tx_on, o_mac_rx_on},
             {28'h0, a[9] & c[11], a[9] & ~c[11], c[3], c[2]});
         chk({30'h0, o_tx_dma_run, o_rx_dma_run}, {30'h0, m[13], m[1]});
      end
      bus_wr(16'h0100, 32'hFFFFFFFF, 4'hF);
      bus_rd(16'h0100, 4'hF, r);
      chk(r, 32'h0);
      bus_rd(OFS_GLUE_B, 4'hF, r);
      chk(r, {16'h0, b[15:0]});
      bus_rd(OFS_GLUE_A, 4'hF, r);
      chk(r, {16'h0, a[15:0]});
      $display("glue test done");
      bus_wr(OFS_OPMODE, 32'h00002002, 4'hF);
      for (int d = 0; d < 2; d++) begin
         i_tx_own <= (d != 0);
         i_rx_own <= (d == 0);
         repeat (4) @(posedge i_mclk);
         bus_rd(OFS_STATUS, 4'hF, r);
         chk(r & 32'h00120000, (d == 0) ? 32'h00100000 : 32'h00020000);
         i_tx_own <= 1'b1;
         i_rx_own <= 1'b1;
         bus_wr((d == 0) ? OFS_TXPOLL : OFS_RXPOLL, 32'h0, 4'hF);
         repeat (3) @(posedge i_mclk);
         bus_rd(OFS_STATUS, 4'hF, r);
         chk(r & 32'h00120000, 32'h0);
      end
      bus_wr(OFS_OPMODE, 32'h0, 4'hF);
      i_tx_done <= 1'b1;
      @(posedge i_mclk);
      i_tx_done <= 1'b0;
      @(posedge i_mclk);
      bus_rd(OFS_STATUS, 4'hF, r);
      chk(r & 32'h10001, 32'h10001);
      for (int k = 0; k < 2; k++) begin
         bus_wr(OFS_STATUS, (k == 0) ? 32'h10000 : 32'h1, 4'hF);
         bus_rd(OFS_STATUS, 4'hF, r);
         chk(r & 32'h10001, (k == 0) ? 32'h1 : 32'h0);
      end
      $display("dma test done");
      bus_wr(OFS_MACCFG, 32'h0, 4'hF);
      for (int i = 0; i < 20; i++) fr.push_back(8'($random(seed)));
      fr[0][0] = 1'b0;
      slot = '{32'h000000B5, 32'h0, 32'h0, 32'h0, 32'h1, 32'hC,
               32'(crc_of(fr, 32'h000000B5)), 32'h0};
      for (int i = 0; i < 8; i++) bus_wr(OFS_WAKE, slot[i], 4'hF);
      bus_wr(OFS_PMT, 32'h5, 4'hF);
      bus_wr(OFS_MACCFG, 32'h4, 4'hF);
      repeat (2) @(posedge i_mclk);
      chk(32'({o_pdown, o_mac_rx_on}), 32'h3);
      for (int k = 0; k < 3; k++) begin
         fb = fr;
         if (k == 0) fb[0][0] = 1'b1;
         if (k == 1) fb[12] = ~fb[12];
         u_phy.send(fb);
         repeat (6) @(posedge i_mclk);
         chk(32'({o_wake_irq, o_pdown}), (k == 2) ? 32'h2 : 32'h1);
      end
      bus_rd(OFS_PMT, 4'hF, r);
      chk(r & 32'h40, 32'h40);
      repeat (2) @(posedge i_mclk);
      chk(32'(o_wake_irq), 32'h0);
      $display("wake test done");
      wrap_up();
   end
endmodule : tb_ethernet_mac_wake_filter_and_glue
